// >>> inc/cfm_pkg.sv
package cfm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LOS_SENS = 8'h04;
    localparam logic [7:0] OFF_OOF_WIN = 8'h08;
    localparam logic [7:0] OFF_LOL_THR = 8'h0c;
    localparam logic [7:0] OFF_LOL_DLY = 8'h10;
    localparam logic [7:0] OFF_LIVE = 8'h14;
    localparam logic [7:0] OFF_STICKY = 8'h18;
    localparam logic [7:0] OFF_MASK = 8'h1c;
    localparam logic [7:0] OFF_LOOP_DF0 = 8'h20;
    localparam logic [7:0] OFF_LOOP_DF3 = 8'h2c;
    localparam logic [7:0] OFF_MEAS = 8'h30;
    // Control field positions
    localparam int CTRL_LOS_DIS = 0;
    localparam int CTRL_REF_LOS_DIS = 5;
    localparam int CTRL_KEEP_OUT = 6;
    localparam int CTRL_REF_SEL = 8;
    localparam int CTRL_PREC_DIS = 11;
    localparam int CTRL_FAST_DIS = 12;
    localparam int CTRL_GAP_EN = 13;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] LOS_SENS_RST = 32'h0000_0000;
    localparam logic [31:0] OOF_WIN_RST = 32'h0020_0060; // 6 ppm window, 2 ppm hysteresis
    localparam logic [31:0] LOL_THR_RST = 32'h0001_000a; // Set 1 ppm, clear 0.1 ppm (0.1 steps)
    localparam logic [31:0] LOL_DLY_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    // Measurement timing
    localparam int CLK_MHZ = 40;
    localparam int LOS_TIMEOUT_NS = 200;
    localparam int LOS_TIMEOUT_CYC = (LOS_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
    localparam int MEAS_WIN_CYC = 1024;
    localparam int FAST_PPM = 4000;
    localparam logic [3:0] GAP_MISS_MAX = 4'h2; // Missed periods a gapped input may show
    localparam int OOF_MAX_16TH = 8000; // 500 ppm in 1/16 steps
    localparam int LOL_MAX_TENTH = 100000; // 10000 ppm in 0.1 steps
endpackage

// >>> src/cfm_monitor.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Valid gapped input raises no faults
// - Four inputs checked loss and range; reference loss
// - Per-cycle timing with programmable missing-edge tolerance
// - Live and sticky signal-loss status per input
// - Each signal-loss detector individually disableable
// - Reference loss disables outputs unless configured
// - Zero-ppm reference selectable: crystal or any input
// - Range fault combines precise and fast monitors
// - Live and sticky range status per input
// - Precise window up to 500 ppm, 1/16 steps
// - Hysteresis between range assert and deassert
// - Fast monitor flags moves beyond 4000 ppm
// - Per-loop lock-loss bit and active-low pin
// - Separate set and clear lock-loss monitors
// - Lock thresholds 0.1 to 6553.5 ppm
// - Optional delay before lock-loss clears
// - Live and sticky lock-loss status per loop
// - Interrupt on any unmasked indicator change
// - Interrupt releases only when unmasked sticky bits cleared
module cfm_monitor #(
    parameter int NIN = 4,
    parameter int NLOOP = 4,
    parameter int MEAS_CYC = cfm_pkg::MEAS_WIN_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clk_input_0,
    input wire logic clk_input_1,
    input wire logic clk_input_2,
    input wire logic clk_input_3,
    input wire logic crystal_ref_input,
    output logic irq_out_n,
    output logic lock_loss_pin_a_n,
    output logic lock_loss_pin_b_n,
    output logic lock_loss_pin_c_n,
    output logic lock_loss_pin_d_n,
    output logic output_enable
);
    localparam int NS = NIN + 1; // Index NIN is the reference input

    // Software-visible configuration and status, then internal state
    logic [31:0] ctrl, los_sens, oof_win, lol_thr, lol_dly, mask;
    logic [31:0] loop_df [NLOOP];
    logic [NS-1:0] sig_loss, sig_loss_stk;
    logic [NIN-1:0] freq_range, freq_range_stk;
    logic [NLOOP-1:0] lock_loss, lock_loss_stk;
    logic [31:0] live_word, stk_word, prev_live;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] s1, s2, s3, lvl, edge_q;
    logic [7:0] gap_cnt [NS];
    logic [3:0] miss_cnt [NS];
    logic [15:0] win_cnt;
    logic [15:0] edges [NS];
    logic [15:0] meas [NS];
    logic [15:0] prev_meas [NIN];
    logic meas_done;
    logic [15:0] lol_tmr [NLOOP];
    logic wr_en, rd_en;
    logic [NS-1:0] sig_loss_raw;

    // Magnitude of difference as parts-per-million scaled by 16
    function automatic logic [31:0] ppm16(input logic [15:0] a, input logic [15:0] r);
        logic [31:0] d;
        d = (a > r) ? 32'(a - r) : 32'(r - a);
        if (r == 16'h0000)
            return 32'hffff_ffff;
        return 32'((64'(d) * 64'd16_000_000) / 64'(r));
    endfunction

    // Tolerated missed periods; gap mode never tolerates fewer than a gapped clock drops
    function automatic logic [3:0] miss_limit(input logic [3:0] sens, input logic gap);
        if (gap && sens < cfm_pkg::GAP_MISS_MAX)
            return cfm_pkg::GAP_MISS_MAX;
        return sens;
    endfunction

    // Window limit in 1/16 ppm, clamped to the widest allowed range
    function automatic logic [31:0] oof_limit(input logic [12:0] w);
        if (32'(w) > 32'(cfm_pkg::OOF_MAX_16TH))
            return 32'(cfm_pkg::OOF_MAX_16TH);
        return 32'(w);
    endfunction

    // Per-loop difference words sit at four aligned offsets; unaligned ones are unmapped
    function automatic logic loop_df_hit(input logic [7:0] a);
        return a >= cfm_pkg::OFF_LOOP_DF0 && a <= cfm_pkg::OFF_LOOP_DF3 && a[1:0] == 2'b00;
    endfunction

    assign raw_in = {crystal_ref_input, clk_input_3, clk_input_2, clk_input_1, clk_input_0};
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    // Three-stage pin synchronisers, rising edge counted when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            lvl <= '0;
            edge_q <= '0;
        end else begin
            s1 <= raw_in;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < NS; i++) begin
                if (s2[i] == s3[i])
                    lvl[i] <= s3[i];
                edge_q[i] <= (s2[i] == s3[i]) && s3[i] && !lvl[i];
            end
        end
    end

    // Per-cycle period timing; sensitivity field sets missed-period tolerance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NS; i++) begin
                gap_cnt[i] <= '0;
                miss_cnt[i] <= '0;
            end
            sig_loss_raw <= '0;
        end else begin
            for (int i = 0; i < NS; i++) begin
                if (edge_q[i]) begin
                    gap_cnt[i] <= '0;
                    miss_cnt[i] <= '0;
                    sig_loss_raw[i] <= 1'b0;
                end else if (gap_cnt[i] == 8'(cfm_pkg::LOS_TIMEOUT_CYC)) begin
                    gap_cnt[i] <= '0;
                    if (miss_cnt[i] >= miss_limit(los_sens[4*(i%8) +: 4],
                            ctrl[cfm_pkg::CTRL_GAP_EN]))
                        sig_loss_raw[i] <= 1'b1;
                    else
                        miss_cnt[i] <= miss_cnt[i] + 4'h1;
                end else begin
                    gap_cnt[i] <= gap_cnt[i] + 8'h01;
                end
            end
        end
    end

    // Live signal-loss with per-detector disable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sig_loss <= '0;
        else begin
            for (int i = 0; i < NIN; i++)
                sig_loss[i] <= sig_loss_raw[i] & ~ctrl[cfm_pkg::CTRL_LOS_DIS + i];
            sig_loss[NIN] <= sig_loss_raw[NIN] & ~ctrl[cfm_pkg::CTRL_REF_LOS_DIS];
        end
    end

    // Edge counts over a fixed window give frequency of every input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt <= '0;
            meas_done <= 1'b0;
            for (int i = 0; i < NS; i++) begin
                edges[i] <= '0;
                meas[i] <= '0;
            end
            for (int i = 0; i < NIN; i++)
                prev_meas[i] <= '0;
        end else begin
            meas_done <= 1'b0;
            if (win_cnt == 16'(MEAS_CYC - 1)) begin
                win_cnt <= '0;
                meas_done <= 1'b1;
                for (int i = 0; i < NS; i++) begin
                    meas[i] <= edges[i];
                    edges[i] <= {15'h0000, edge_q[i]};
                end
                for (int i = 0; i < NIN; i++)
                    prev_meas[i] <= meas[i];
            end else begin
                win_cnt <= win_cnt + 16'h0001;
                for (int i = 0; i < NS; i++)
                    edges[i] <= edges[i] + 16'(edge_q[i]);
            end
        end
    end

    // Range fault: precise window with hysteresis, fast step check, selectable reference
    always_ff @(posedge pclk or negedge presetn) begin
        logic [15:0] ref_f;
        logic [31:0] dev;
        logic [31:0] step;
        logic prec, fast;
        if (!presetn) begin
            freq_range <= '0;
        end else if (meas_done) begin
            ref_f = (ctrl[cfm_pkg::CTRL_REF_SEL +: 3] < 3'(NIN)) ?
                meas[ctrl[cfm_pkg::CTRL_REF_SEL +: 2]] : meas[NIN];
            for (int i = 0; i < NIN; i++) begin
                dev = ppm16(meas[i], ref_f);
                step = ppm16(meas[i], prev_meas[i]);
                if (freq_range[i])
                    prec = dev > oof_limit(oof_win[12:0]) - 32'(oof_win[28:16]);
                else
                    prec = dev > oof_limit(oof_win[12:0]);
                fast = step > 32'(cfm_pkg::FAST_PPM * 16);
                freq_range[i] <= (prec & ~ctrl[cfm_pkg::CTRL_PREC_DIS]) |
                    (fast & ~ctrl[cfm_pkg::CTRL_FAST_DIS]);
                if (ctrl[cfm_pkg::CTRL_GAP_EN] && !sig_loss[i] && !fast)
                    freq_range[i] <= 1'b0;
            end
        end
    end

    // Lock-loss per loop: set and clear monitors with delayed clear
    always_ff @(posedge pclk or negedge presetn) begin
        logic [31:0] df;
        if (!presetn) begin
            lock_loss <= '1;
            for (int l = 0; l < NLOOP; l++)
                lol_tmr[l] <= '0;
        end else begin
            for (int l = 0; l < NLOOP; l++) begin
                df = 32'(loop_df[l][16:0]); // Difference in 0.1 ppm steps
                if (df > 32'(lol_thr[15:0])) begin
                    lock_loss[l] <= 1'b1;
                    lol_tmr[l] <= '0;
                end else if (lock_loss[l] && df < 32'(lol_thr[31:16])) begin
                    if (lol_tmr[l] >= lol_dly[15:0])
                        lock_loss[l] <= 1'b0;
                    else
                        lol_tmr[l] <= lol_tmr[l] + 16'h0001;
                end else begin
                    lol_tmr[l] <= '0;
                end
            end
        end
    end

    assign live_word = {16'h0000, 3'b000, lock_loss, freq_range, sig_loss};

    // Sticky bits: hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_loss_stk <= '0;
            freq_range_stk <= '0;
            lock_loss_stk <= '0;
        end else begin
            logic [31:0] clr;
            clr = (wr_en && paddr == cfm_pkg::OFF_STICKY) ? pwdata : 32'h0000_0000;
            sig_loss_stk <= sig_loss | (sig_loss_stk & ~clr[4:0]);
            freq_range_stk <= freq_range | (freq_range_stk & ~clr[8:5]);
            lock_loss_stk <= lock_loss | (lock_loss_stk & ~clr[12:9]);
        end
    end

    assign stk_word = {19'h00000, lock_loss_stk, freq_range_stk, sig_loss_stk};

    // Interrupt latch: set on unmasked change, held until unmasked stickies cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_live <= '0;
            irq_out_n <= 1'b1;
        end else begin
            prev_live <= live_word;
            if (|((live_word ^ prev_live) & ~mask))
                irq_out_n <= 1'b0;
            else if ((stk_word & ~mask) == 32'h0000_0000)
                irq_out_n <= 1'b1;
        end
    end

    // Lock-loss pins and output gating on reference loss
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_loss_pin_a_n <= 1'b0;
            lock_loss_pin_b_n <= 1'b0;
            lock_loss_pin_c_n <= 1'b0;
            lock_loss_pin_d_n <= 1'b0;
            output_enable <= 1'b0;
        end else begin
            lock_loss_pin_a_n <= ~lock_loss[0];
            lock_loss_pin_b_n <= ~lock_loss[1];
            lock_loss_pin_c_n <= ~lock_loss[2];
            lock_loss_pin_d_n <= ~lock_loss[3];
            output_enable <= ~sig_loss[NIN] | ctrl[cfm_pkg::CTRL_KEEP_OUT];
        end
    end

    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= cfm_pkg::CTRL_RST;
            los_sens <= cfm_pkg::LOS_SENS_RST;
            oof_win <= cfm_pkg::OOF_WIN_RST;
            lol_thr <= cfm_pkg::LOL_THR_RST;
            lol_dly <= cfm_pkg::LOL_DLY_RST;
            mask <= cfm_pkg::MASK_RST;
            for (int l = 0; l < NLOOP; l++)
                loop_df[l] <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                cfm_pkg::OFF_CTRL: ctrl <= pwdata;
                cfm_pkg::OFF_LOS_SENS: los_sens <= pwdata;
                cfm_pkg::OFF_OOF_WIN: oof_win <= pwdata;
                cfm_pkg::OFF_LOL_THR: lol_thr <= pwdata;
                cfm_pkg::OFF_LOL_DLY: lol_dly <= pwdata;
                cfm_pkg::OFF_MASK: mask <= pwdata;
                default: begin
                    if (loop_df_hit(paddr))
                        loop_df[paddr[3:2]] <= pwdata;
                end
            endcase
        end
    end

    // Read data, zero-wait answer; unmapped addresses return slverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= '0;
                unique case (paddr)
                    cfm_pkg::OFF_CTRL: prdata <= ctrl;
                    cfm_pkg::OFF_LOS_SENS: prdata <= los_sens;
                    cfm_pkg::OFF_OOF_WIN: prdata <= oof_win;
                    cfm_pkg::OFF_LOL_THR: prdata <= lol_thr;
                    cfm_pkg::OFF_LOL_DLY: prdata <= lol_dly;
                    cfm_pkg::OFF_LIVE: prdata <= live_word;
                    cfm_pkg::OFF_STICKY: prdata <= stk_word;
                    cfm_pkg::OFF_MASK: prdata <= mask;
                    cfm_pkg::OFF_MEAS: prdata <= {16'h0000, meas[NIN]};
                    default: begin
                        if (loop_df_hit(paddr))
                            prdata <= loop_df[paddr[3:2]];
                        else
                            pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// >>> test/cfm_clock_source.sv
`timescale 1ns/1ps
// Upstream clock sources; a stopped source stands low
module cfm_clock_source (
    input wire logic [4:0] run_en,
    input wire logic gap_en,
    input wire logic slow_3,
    output logic clk_input_0,
    output logic clk_input_1,
    output logic clk_input_2,
    output logic clk_input_3,
    output logic crystal_ref_input
);
    logic [4:0] lvl;
    assign {crystal_ref_input, clk_input_3, clk_input_2, clk_input_1, clk_input_0} = lvl;
    // 10 MHz sources; input 0 may drop two cycles of each eight
    for (genvar i = 0; i < 5; i++) begin : g_src
        initial begin
            int ph;
            ph = 0;
            lvl[i] = 1'b0;
            forever begin
                ph = (ph + 1) % 8;
                if (run_en[i] && !(i == 0 && gap_en && ph >= 6)) begin
                    lvl[i] = 1'b1;
                    #((i == 3 && slow_3) ? 52.5 : 50.0);
                    lvl[i] = 1'b0;
                    #((i == 3 && slow_3) ? 52.5 : 50.0);
                end else begin
                    #100.0;
                end
            end
        end
    end
endmodule

// >>> test/cfm_monitor_assertions.sv
`timescale 1ns/1ps
// Port-level checks of the register bus, interrupt and lock pins
module cfm_monitor_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq_out_n,
    input wire logic lock_loss_pin_a_n,
    input wire logic lock_loss_pin_b_n,
    input wire logic lock_loss_pin_c_n,
    input wire logic lock_loss_pin_d_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] since_clr;
    wire logic bad_addr = paddr > cfm_pkg::OFF_MEAS || paddr[1:0] != 2'b00;
    wire logic clr_wr = psel && penable && pwrite
        && (paddr == cfm_pkg::OFF_STICKY || paddr == cfm_pkg::OFF_MASK);
    wire logic [3:0] pins_n = {lock_loss_pin_d_n, lock_loss_pin_c_n,
        lock_loss_pin_b_n, lock_loss_pin_a_n};
    // Cycles since software last wrote sticky or mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_clr <= 4'hf;
        end else if (clr_wr) begin
            since_clr <= 4'h0;
        end else if (since_clr != 4'hf) begin
            since_clr <= since_clr + 4'h1;
        end
    end
    a_setup_ready: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    a_err_decode: assert property (pready |-> pslverr == bad_addr)
        else $error("slave error does not match decode");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    a_irq_release: assert property ($rose(irq_out_n) |-> since_clr < 4'h4)
        else $error("interrupt released without software clear");
    a_lock_pin_live: assert property (pready && !pwrite && paddr == cfm_pkg::OFF_LIVE
        && $stable(pins_n) |-> prdata[12:9] == ~pins_n)
        else $error("lock pins disagree with live status");
endmodule
bind cfm_monitor cfm_monitor_assertions i_cfm_monitor_assertions (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_out_n(irq_out_n),
    .lock_loss_pin_a_n(lock_loss_pin_a_n), .lock_loss_pin_b_n(lock_loss_pin_b_n),
    .lock_loss_pin_c_n(lock_loss_pin_c_n), .lock_loss_pin_d_n(lock_loss_pin_d_n));

// >>> test/tb_cfm_monitor.sv
`timescale 1ns/1ps
module tb_cfm_monitor;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_out_n, oe, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic c0, c1, c2, c3, cr, gap_en, slow_3;
    logic [3:0] pins_n;
    logic [4:0] run_en;
    int error_cnt, samples_checked;
    cfm_monitor #(.NIN(4), .NLOOP(4), .MEAS_CYC(1024)) i_cfm_monitor (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clk_input_0(c0), .clk_input_1(c1), .clk_input_2(c2), .clk_input_3(c3),
        .crystal_ref_input(cr), .irq_out_n(irq_out_n), .lock_loss_pin_a_n(pins_n[0]),
        .lock_loss_pin_b_n(pins_n[1]), .lock_loss_pin_c_n(pins_n[2]),
        .lock_loss_pin_d_n(pins_n[3]), .output_enable(oe));
    cfm_clock_source i_cfm_clock_source (.run_en(run_en), .gap_en(gap_en), .slow_3(slow_3),
        .clk_input_0(c0), .clk_input_1(c1), .clk_input_2(c2), .clk_input_3(c3),
        .crystal_ref_input(cr));
    // 40 MHz bus clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One bus transfer; read data and error land in q and e
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            check("apb_ready", 32'h0, 32'h1);
            final_report();
        end else begin
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(name, q & m, x);
    endtask
    // Rereads until the masked value matches, bounded
    task automatic poll(input string name, input logic [31:0] m, input logic [31:0] x);
        int n;
        n = 0;
        do begin
            repeat (20) @(posedge pclk);
            apb(1'b0, cfm_pkg::OFF_LIVE, 32'h0);
            n++;
        end while ((q & m) !== x && n < 300);
        check(name, q & m, x);
        if ((q & m) !== x) final_report();
    endtask
    // Stops a source, checks live and interrupt, restarts, clears stickies
    task automatic drop(input int i, input logic [31:0] m, input logic irq_exp);
        run_en[i] <= 1'b0;
        poll("loss_live", m, m);
        check("irq_drop", {31'h0, irq_out_n}, {31'h0, irq_exp});
        run_en[i] <= 1'b1;
        // Let two measurement windows close; the fast step check holds the range flag until the third, so the poll waits
        repeat (2100) @(posedge pclk);
        poll("loss_gone", 32'h1fff, 32'h0);
        rdchk("loss_sticky", cfm_pkg::OFF_STICKY, m, m);
        wr(cfm_pkg::OFF_STICKY, 32'h1fff);
        rdchk("sticky_clr", cfm_pkg::OFF_STICKY, 32'h1fff, 32'h0);
        check("irq_clr", {31'h0, irq_out_n}, 32'h1);
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, gap_en, slow_3} = '0;
        run_en = 5'h1f;
        error_cnt = 0;
        samples_checked = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctrl", cfm_pkg::OFF_CTRL, '1, cfm_pkg::CTRL_RST);
        rdchk("oof_win", cfm_pkg::OFF_OOF_WIN, '1, cfm_pkg::OOF_WIN_RST);
        rdchk("lol_thr", cfm_pkg::OFF_LOL_THR, '1, cfm_pkg::LOL_THR_RST);
        rdchk("mask", cfm_pkg::OFF_MASK, '1, cfm_pkg::MASK_RST);
        apb(1'b0, 8'h34, 32'h0);
        check("unmapped", {31'h0, e}, 32'h1);
        for (int i = 0; i < 4; i++) wr(8'(cfm_pkg::OFF_LOOP_DF0 + 4 * i), 32'h0);
        poll("all_clear", 32'h1fff, 32'h0);
        check("lol_pins", {28'h0, pins_n}, 32'hf);
        check("out_en", {31'h0, oe}, 32'h1);
        wr(cfm_pkg::OFF_STICKY, 32'h1fff);
        repeat (2) @(posedge pclk);
        check("irq_idle", {31'h0, irq_out_n}, 32'h1);
        // Set above 1 ppm, hold between thresholds, clear after delay
        wr(cfm_pkg::OFF_LOL_DLY, 32'd50);
        wr(cfm_pkg::OFF_LOOP_DF0, 32'd20);
        poll("lol_set", 32'h200, 32'h200);
        check("irq_lol", {31'h0, irq_out_n}, 32'h0);
        wr(cfm_pkg::OFF_LOOP_DF0, 32'd5);
        repeat (80) @(posedge pclk);
        rdchk("lol_hyst", cfm_pkg::OFF_LIVE, 32'h200, 32'h200);
        wr(cfm_pkg::OFF_LOOP_DF0, 32'd0);
        repeat (20) @(posedge pclk);
        check("lol_delay", {31'h0, pins_n[0]}, 32'h0);
        poll("lol_clr", 32'h200, 32'h0);
        check("pin_a", {31'h0, pins_n[0]}, 32'h1);
        wr(cfm_pkg::OFF_STICKY, 32'h200);
        drop(1, 32'h2, 1'b0);
        wr(cfm_pkg::OFF_MASK, 32'h1fff);
        drop(2, 32'h4, 1'b1);
        wr(cfm_pkg::OFF_MASK, 32'h0);
        // Disabled detector never reports
        wr(cfm_pkg::OFF_CTRL, 32'h2);
        run_en[1] <= 1'b0;
        repeat (300) @(posedge pclk);
        rdchk("los_dis", cfm_pkg::OFF_LIVE, 32'h2, 32'h0);
        run_en[1] <= 1'b1;
        // Reference loss gates outputs unless kept on
        wr(cfm_pkg::OFF_CTRL, 32'h0);
        run_en[4] <= 1'b0;
        poll("ref_loss", 32'h10, 32'h10);
        check("oe_off", {31'h0, oe}, 32'h0);
        wr(cfm_pkg::OFF_CTRL, 32'h40);
        rdchk("ctrl_keep", cfm_pkg::OFF_CTRL, 32'h40, 32'h40);
        check("oe_keep", {31'h0, oe}, 32'h1);
        run_en[4] <= 1'b1;
        wr(cfm_pkg::OFF_CTRL, 32'h0);
        poll("ref_back", 32'h1fff, 32'h0);
        // Input 3 off by 5 percent, then used as zero reference
        slow_3 <= 1'b1;
        poll("range_3", 32'h1e0, 32'h100);
        wr(cfm_pkg::OFF_CTRL, 32'h300);
        poll("ref_sel", 32'h1e0, 32'h0e0);
        wr(cfm_pkg::OFF_CTRL, 32'h1800);
        poll("mon_dis", 32'h1e0, 32'h0);
        slow_3 <= 1'b0;
        // Gapped input raises no faults
        // Crystal as zero reference, so the gapped input reads far off its nominal rate
        wr(cfm_pkg::OFF_CTRL, 32'h2400);
        gap_en <= 1'b1;
        repeat (4200) @(posedge pclk);
        rdchk("gapped", cfm_pkg::OFF_LIVE, 32'h221, 32'h0);
        final_report();
    end
endmodule
